// File: hdl/channel_trim_volume_regs.sv
`timescale 1ns/100ps
// How it works
// - Delay PDM-selected samples by phase code modulator cycles
// - Phase code zero adds no delay
// - Volume code zero mutes the channel
// - Volume in half-dB steps, 201 is 0 dB
// - Volume registers reset to C9h, read/write
// - Gain trim from bits 7-4, 0.1 dB steps
// - Gain trim resets 80h, low nibble reads zero
// - Channel 5/6 settings affect PDM inputs only
// - Channel 5/6 registers at 52h-54h, 57h-59h
// - Channel 4 phase register at 4Fh, reset zero
module channel_trim_volume_regs #(
	parameter int SAMPLE_W = 24
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                mod_clk_tick,
	input  wire logic [2:0]          sample_valid,
	input  wire logic [SAMPLE_W-1:0] ch4_sample,
	input  wire logic [SAMPLE_W-1:0] ch5_sample,
	input  wire logic [SAMPLE_W-1:0] ch6_sample,
	output logic      [2:0]          out_valid,
	output logic      [SAMPLE_W-1:0] ch4_out,
	output logic      [SAMPLE_W-1:0] ch5_out,
	output logic      [SAMPLE_W-1:0] ch6_out,
	output trim_regs_pkg::chan_cfg_s ch5_cfg,
	output trim_regs_pkg::chan_cfg_s ch6_cfg,
	output logic      [7:0]          ch4_phase_delay_code
);
	logic [7:0] ch4_phase_trim;
	logic [7:0] ch5_volume;
	logic [7:0] ch5_gain_trim;
	logic [7:0] ch5_phase_trim;
	logic [7:0] ch6_volume;
	logic [7:0] ch6_gain_trim;
	logic [7:0] ch6_phase_trim;
	logic [7:0] pdm_select;

	// APB decode: registers at four times their index, always one wait state
	wire        access  = psel && penable;
	wire [9:0]  idx     = paddr[11:2];
	wire        aligned = (paddr[1:0] == 2'b00);
	wire        wr_lane = pstrb[0];
	wire        hit_c4p = aligned && (idx == {2'b00, trim_regs_pkg::IDX_CH4_PHASE});
	wire        hit_c5v = aligned && (idx == {2'b00, trim_regs_pkg::IDX_CH5_VOLUME});
	wire        hit_c5g = aligned && (idx == {2'b00, trim_regs_pkg::IDX_CH5_GAIN});
	wire        hit_c5p = aligned && (idx == {2'b00, trim_regs_pkg::IDX_CH5_PHASE});
	wire        hit_c6v = aligned && (idx == {2'b00, trim_regs_pkg::IDX_CH6_VOLUME});
	wire        hit_c6g = aligned && (idx == {2'b00, trim_regs_pkg::IDX_CH6_GAIN});
	wire        hit_c6p = aligned && (idx == {2'b00, trim_regs_pkg::IDX_CH6_PHASE});
	wire        hit_sel = aligned && (idx == {2'b00, trim_regs_pkg::IDX_PDM_SELECT});
	wire        hit_any = hit_c4p | hit_c5v | hit_c5g | hit_c5p | hit_c6v | hit_c6g
	                      | hit_c6p | hit_sel;
	// A write lands only at the edge that completes the transfer
	wire        wr_en   = access && pready && pwrite && hit_any && wr_lane;
	wire [7:0]  wbyte   = pwdata[7:0];
	// Reserved low nibble of gain trim is never stored
	wire [7:0]  wgain   = {wbyte[7:4], 4'h0};
	wire [7:0]  rd_mux  = hit_c4p ? ch4_phase_trim :
	                      hit_c5v ? ch5_volume :
	                      hit_c5g ? ch5_gain_trim :
	                      hit_c5p ? ch5_phase_trim :
	                      hit_c6v ? ch6_volume :
	                      hit_c6g ? ch6_gain_trim :
	                      hit_c6p ? ch6_phase_trim :
	                      hit_sel ? pdm_select : 8'h00;
	wire [31:0] next_prdata  = (access && !pwrite) ? {24'h000000, rd_mux} : 32'h00000000;
	wire        next_pslverr = access && !hit_any;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch4_phase_trim <= trim_regs_pkg::RST_PHASE;
			ch5_volume     <= trim_regs_pkg::RST_VOLUME;
			ch5_gain_trim  <= trim_regs_pkg::RST_GAIN;
			ch5_phase_trim <= trim_regs_pkg::RST_PHASE;
			ch6_volume     <= trim_regs_pkg::RST_VOLUME;
			ch6_gain_trim  <= trim_regs_pkg::RST_GAIN;
			ch6_phase_trim <= trim_regs_pkg::RST_PHASE;
			pdm_select     <= trim_regs_pkg::RST_PDM_SELECT;
		end else if (wr_en) begin
			if (hit_c4p) ch4_phase_trim <= wbyte;
			if (hit_c5v) ch5_volume     <= wbyte;
			if (hit_c5g) ch5_gain_trim  <= wgain;
			if (hit_c5p) ch5_phase_trim <= wbyte;
			if (hit_c6v) ch6_volume     <= wbyte;
			if (hit_c6g) ch6_gain_trim  <= wgain;
			if (hit_c6p) ch6_phase_trim <= wbyte;
			if (hit_sel) pdm_select     <= wbyte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h00000000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			prdata  <= next_prdata;
			pready  <= access && !pready;
			pslverr <= next_pslverr && !pready;
		end
	end

	// Settings exported to the decimation datapath; PDM flag tells it whether
	// the trims are to be honoured on that channel
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ch5_cfg              <= '0;
			ch6_cfg              <= '0;
			ch4_phase_delay_code <= trim_regs_pkg::RST_PHASE;
		end else begin
			// Volume and gain trim codes are scaled downstream
			ch5_cfg              <= '{ch5_volume, ch5_gain_trim[7:4], ch5_phase_trim,
			                          pdm_select[trim_regs_pkg::PDM_CH5_BIT]};
			ch6_cfg              <= '{ch6_volume, ch6_gain_trim[7:4], ch6_phase_trim,
			                          pdm_select[trim_regs_pkg::PDM_CH6_BIT]};
			ch4_phase_delay_code <= ch4_phase_trim;
		end
	end

	// Per-channel phase delay line, one entry per modulator tick. A code
	// change takes effect on the next sample; the line is not flushed, so one
	// stale sample may appear, which is cheaper than a flush on every write.
	logic [SAMPLE_W-1:0] dly_mem [3][trim_regs_pkg::PHASE_DEPTH];
	logic [7:0]          wptr;
	logic [SAMPLE_W-1:0] ch_in  [3];
	logic [7:0]          code   [3];
	logic                use_pd [3];
	logic [SAMPLE_W-1:0] dly_out[3];
	assign ch_in[0]  = ch4_sample;
	assign ch_in[1]  = ch5_sample;
	assign ch_in[2]  = ch6_sample;
	assign code[0]   = ch4_phase_trim;
	assign code[1]   = ch5_phase_trim;
	assign code[2]   = ch6_phase_trim;
	assign use_pd[0] = pdm_select[trim_regs_pkg::PDM_CH4_BIT];
	assign use_pd[1] = pdm_select[trim_regs_pkg::PDM_CH5_BIT];
	assign use_pd[2] = pdm_select[trim_regs_pkg::PDM_CH6_BIT];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wptr <= 8'h00;
		end else if (mod_clk_tick) begin
			wptr <= wptr + 8'h01;
		end
	end

	for (genvar c = 0; c < 3; c++) begin : g_ch
		logic [7:0] rptr;
		logic [7:0] eff_code;
		assign eff_code   = use_pd[c] ? code[c] : 8'h00;
		assign rptr       = wptr - eff_code;
		assign dly_out[c] = (eff_code == 8'h00) ? ch_in[c]
		                    : dly_mem[c][rptr];
		always_ff @(posedge pclk) begin
			if (mod_clk_tick) begin
				dly_mem[c][wptr] <= ch_in[c];
			end
		end
	end

	// Volume/mute: mute forces zero; the gain scaling itself lives in the
	// filter datapath, which reads the exported codes
	function automatic logic [SAMPLE_W-1:0] apply_mute(input logic [SAMPLE_W-1:0] s,
	                                                   input logic [7:0] vol,
	                                                   input logic pdm);
		apply_mute = (pdm && vol == trim_regs_pkg::VOLUME_MUTE) ? '0 : s;
	endfunction

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 3'b000;
			ch4_out   <= '0;
			ch5_out   <= '0;
			ch6_out   <= '0;
		end else begin
			out_valid <= sample_valid & {3{mod_clk_tick}};
			ch4_out   <= dly_out[0];
			ch5_out   <= apply_mute(dly_out[1], ch5_volume, use_pd[1]);
			ch6_out   <= apply_mute(dly_out[2], ch6_volume, use_pd[2]);
		end
	end

	property p_vol_reset;
		@(posedge pclk) $rose(presetn) |-> ch5_volume == trim_regs_pkg::RST_VOLUME
		                                   && ch6_volume == trim_regs_pkg::RST_VOLUME;
	endproperty
	a_vol_reset: assert property (p_vol_reset) else $error("volume reset wrong");

	property p_trim_reset;
		@(posedge pclk) $rose(presetn) |-> ch5_gain_trim == trim_regs_pkg::RST_GAIN
		                                   && ch6_gain_trim == trim_regs_pkg::RST_GAIN;
	endproperty
	a_trim_reset: assert property (p_trim_reset) else $error("gain trim reset wrong");

	property p_phase_reset;
		@(posedge pclk) $rose(presetn) |-> ch4_phase_trim == trim_regs_pkg::RST_PHASE
		                                   && ch5_phase_trim == trim_regs_pkg::RST_PHASE;
	endproperty
	a_phase_reset: assert property (p_phase_reset) else $error("phase reset wrong");

	property p_gain_low;
		@(posedge pclk) disable iff (!presetn) ch5_gain_trim[3:0] == 4'h0 && ch6_gain_trim[3:0] == 4'h0;
	endproperty
	a_gain_low: assert property (p_gain_low) else $error("gain reserved bits set");

	property p_wr5v;
		@(posedge pclk) disable iff (!presetn) wr_en && hit_c5v |=> ch5_volume == $past(wbyte);
	endproperty
	a_wr5v: assert property (p_wr5v) else $error("ch5 volume write lost");

	property p_wr5g;
		@(posedge pclk) disable iff (!presetn)
			wr_en && hit_c5g |=> ch5_gain_trim[7:4] == $past(wbyte[7:4]);
	endproperty
	a_wr5g: assert property (p_wr5g) else $error("ch5 gain trim write lost");

	property p_wr6v;
		@(posedge pclk) disable iff (!presetn) wr_en && hit_c6v |=> ch6_volume == $past(wbyte);
	endproperty
	a_wr6v: assert property (p_wr6v) else $error("ch6 volume write lost");

	property p_hold;
		@(posedge pclk) disable iff (!presetn)
			!wr_en |=> $stable(ch4_phase_trim) && $stable(ch5_volume) && $stable(ch5_gain_trim)
			           && $stable(ch5_phase_trim) && $stable(ch6_volume) && $stable(ch6_gain_trim);
	endproperty
	a_hold: assert property (p_hold) else $error("setting changed without write");

	property p_wr4p;
		@(posedge pclk) disable iff (!presetn) wr_en && hit_c4p |=> ch4_phase_trim == $past(wbyte);
	endproperty
	a_wr4p: assert property (p_wr4p) else $error("ch4 phase write lost");

	property p_mute;
		@(posedge pclk) disable iff (!presetn)
			use_pd[1] && ch5_volume == trim_regs_pkg::VOLUME_MUTE |=> ch5_out == '0;
	endproperty
	a_mute: assert property (p_mute) else $error("mute failed");

	property p_mute6;
		@(posedge pclk) disable iff (!presetn)
			use_pd[2] && ch6_volume == trim_regs_pkg::VOLUME_MUTE |=> ch6_out == '0;
	endproperty
	a_mute6: assert property (p_mute6) else $error("ch6 mute failed");

	wire eff_zero5 = ch5_phase_trim == trim_regs_pkg::RST_PHASE && use_pd[1]
	                 && ch5_volume != trim_regs_pkg::VOLUME_MUTE;
	property p_nodelay;
		@(posedge pclk) disable iff (!presetn) eff_zero5 |=> ch5_out == $past(ch5_sample);
	endproperty
	a_nodelay: assert property (p_nodelay) else $error("zero code delayed");

	property p_ready;
		@(posedge pclk) disable iff (!presetn) access && !pready |=> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("no ready");

	property p_ready_pulse;
		@(posedge pclk) disable iff (!presetn) pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");

	property p_nonpdm;
		@(posedge pclk) disable iff (!presetn) !use_pd[2] |=> ch6_out == $past(ch6_sample);
	endproperty
	a_nonpdm: assert property (p_nonpdm) else $error("non-PDM channel altered");

	property p_err;
		@(posedge pclk) disable iff (!presetn) access && !hit_any && !pready |=> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("unmapped not flagged");

	property p_ok;
		@(posedge pclk) disable iff (!presetn) access && hit_any && !pready |=> !pslverr;
	endproperty
	a_ok: assert property (p_ok) else $error("mapped access flagged");

	property p_rd_wr;
		@(posedge pclk) disable iff (!presetn) access && pwrite |=> prdata == 32'h00000000;
	endproperty
	a_rd_wr: assert property (p_rd_wr) else $error("read data on write");

	property p_cfg5;
		@(posedge pclk) disable iff (!presetn)
			1'b1 |=> ch5_cfg.volume == $past(ch5_volume) && ch5_cfg.gain == $past(ch5_gain_trim[7:4])
			         && ch5_cfg.phase == $past(ch5_phase_trim);
	endproperty
	a_cfg5: assert property (p_cfg5) else $error("ch5 settings not exported");

	property p_cfg6;
		@(posedge pclk) disable iff (!presetn)
			1'b1 |=> ch6_cfg.pdm == $past(use_pd[2]) && ch6_cfg.volume == $past(ch6_volume);
	endproperty
	a_cfg6: assert property (p_cfg6) else $error("ch6 settings not exported");

	property p_outvalid;
		@(posedge pclk) disable iff (!presetn)
			1'b1 |=> out_valid == $past(sample_valid & {3{mod_clk_tick}});
	endproperty
	a_outvalid: assert property (p_outvalid) else $error("output valid wrong");

	property p_code4;
		@(posedge pclk) disable iff (!presetn) 1'b1 |=> ch4_phase_delay_code == $past(ch4_phase_trim);
	endproperty
	a_code4: assert property (p_code4) else $error("ch4 phase code not exported");

	c_err: cover property (@(posedge pclk) access && !hit_any && pready);
	c_nonpdm: cover property (@(posedge pclk) mod_clk_tick && !use_pd[1]);
	c_wr: cover property (@(posedge pclk) wr_en && hit_c5g);
	c_mute: cover property (@(posedge pclk) use_pd[1] && ch5_volume == 8'h00);
	c_dly: cover property (@(posedge pclk) mod_clk_tick && ch5_phase_trim == 8'hFF && use_pd[1]);
endmodule

// File: hdl/trim_regs_pkg.sv
package trim_regs_pkg;
	localparam int         DATA_W          = 8;
	localparam int         PADDR_W         = 12;
	// Printed offsets are not all multiples of four: each is a register index,
	// the byte address is four times the index
	localparam logic [7:0] IDX_CH4_PHASE   = 8'h4F;
	localparam logic [7:0] IDX_CH5_VOLUME  = 8'h52;
	localparam logic [7:0] IDX_CH5_GAIN    = 8'h53;
	localparam logic [7:0] IDX_CH5_PHASE   = 8'h54;
	localparam logic [7:0] IDX_CH6_VOLUME  = 8'h57;
	localparam logic [7:0] IDX_CH6_GAIN    = 8'h58;
	localparam logic [7:0] IDX_CH6_PHASE   = 8'h59;
	localparam logic [7:0] IDX_PDM_SELECT  = 8'h60;
	localparam logic [7:0] RST_VOLUME      = 8'hC9;
	localparam logic [7:0] RST_GAIN        = 8'h80;
	localparam logic [7:0] RST_PHASE       = 8'h00;
	localparam logic [7:0] RST_PDM_SELECT  = 8'h00;
	localparam logic [7:0] VOLUME_MUTE     = 8'h00;
	localparam logic [3:0] GAIN_UNITY      = 4'h8;
	localparam int         GAIN_FIELD_LSB  = 4;
	localparam int         PHASE_DEPTH     = 256;
	localparam int         PDM_CH5_BIT     = 0;
	localparam int         PDM_CH6_BIT     = 1;
	localparam int         PDM_CH4_BIT     = 2;

	typedef struct packed {
		logic [7:0] volume;
		logic [3:0] gain;
		logic [7:0] phase;
		logic       pdm;
	} chan_cfg_s;
endpackage

// File: tb/testbench.sv
`timescale 1ns/100ps
module testbench;
	logic                     pclk = 1'b0;
	logic                     presetn = 1'b0;
	logic                     psel = 1'b0;
	logic                     penable = 1'b0;
	logic                     pwrite = 1'b0;
	logic [11:0]              paddr = 12'h000;
	logic [31:0]              pwdata = 32'h0;
	logic [3:0]               pstrb = 4'hF;
	logic [31:0]              prdata;
	logic                     pready;
	logic                     pslverr;
	logic                     tick = 1'b0;
	logic [2:0]               s_valid = 3'h0;
	logic [2:0]               out_valid;
	logic [23:0]              s4 = 24'h0;
	logic [23:0]              s5 = 24'h0;
	logic [23:0]              s6 = 24'h0;
	logic [23:0]              o4;
	logic [23:0]              o5;
	logic [23:0]              o6;
	trim_regs_pkg::chan_cfg_s cfg5;
	trim_regs_pkg::chan_cfg_s cfg6;
	logic [7:0]               code4;
	int                       failures = 0;
	int                       n_checks = 0;
	logic [7:0]               idx[8] = '{8'h4F, 8'h52, 8'h53, 8'h54, 8'h57, 8'h58, 8'h59, 8'h60};
	logic [7:0]               rst[8] = '{8'h00, 8'hC9, 8'h80, 8'h00, 8'hC9, 8'h80, 8'h00, 8'h00};
	logic [31:0]              rd;
	logic                     err;
	logic [23:0]              h4[$];
	logic [23:0]              h6[$];
	logic [23:0]              h5[$];
	logic [31:0]              r;
	logic [7:0]               pc;

	always #25 pclk = ~pclk;

	channel_trim_volume_regs #(.SAMPLE_W(24)) u_dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.mod_clk_tick(tick), .sample_valid(s_valid), .ch4_sample(s4), .ch5_sample(s5),
		.ch6_sample(s6), .out_valid(out_valid), .ch4_out(o4), .ch5_out(o5), .ch6_out(o6),
		.ch5_cfg(cfg5), .ch6_cfg(cfg6), .ch4_phase_delay_code(code4));

	function automatic logic [11:0] badr(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			failures++;
		end
	endtask

	// Held steady until pready is sampled high, then released a full cycle before the next
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 20) begin
			@(posedge pclk);
			n++;
		end
		if (n == 20) begin
			failures++;
			tally_and_finish();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	// Runs the sample stream and checks the last output against the bench's history
	task automatic stream(input logic [7:0] d4, input logic mute5);
		h4 = {};
		h6 = {};
		h5 = {};
		for (int i = 0; i < 12; i++) begin
			@(posedge pclk);
			r = $urandom;
			if (i > 0) begin
				h4.push_front(s4);
				h6.push_front(s6);
				h5.push_front(s5);
			end
			tick <= 1'b1;
			s_valid <= 3'h7;
			s4 <= r[23:0];
			s5 <= r[31:8];
			s6 <= ~r[23:0];
			#1;
			if (i > 0)
				check("out_valid", 32'h7, {29'h0, out_valid});
		end
		check("ch4_out", {8'h0, h4[d4]}, {8'h0, o4});
		check("ch6_out", {8'h0, h6[0]}, {8'h0, o6});
		if (mute5)
			check("ch5_out", 32'h0, {8'h0, o5});
		else
			check("ch5_out", {8'h0, h5[0]}, {8'h0, o5});
		$display("stream test done");
	endtask

	initial begin
		void'($urandom(32'h6ce3));
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		for (int i = 0; i < 8; i++) begin
			apb(1'b0, badr(idx[i]), 32'h0);
			check("reset value", {24'h0, rst[i]}, rd);
		end
		check("ch5_cfg", {11'h0, trim_regs_pkg::RST_VOLUME, trim_regs_pkg::RST_GAIN[7:4],
			trim_regs_pkg::RST_PHASE, 1'b0}, {11'h0, cfg5});
		$display("reset test done");
		for (int i = 0; i < 8; i++) begin
			r = $urandom;
			apb(1'b1, badr(idx[i]), r);
			apb(1'b0, badr(idx[i]), 32'h0);
			if (idx[i] == 8'h53 || idx[i] == 8'h58)
				check("trim rw", {24'h0, r[7:4], 4'h0}, rd);
			else
				check("reg rw", {24'h0, r[7:0]}, rd);
		end
		apb(1'b0, 12'h149, 32'h0);
		check("unaligned err", 32'h1, {31'h0, err});
		apb(1'b1, 12'h144, 32'hFF);
		check("unmapped err", 32'h1, {31'h0, err});
		$display("access test done");
		pc = 8'($urandom_range(7, 1));
		apb(1'b1, badr(8'h60), 32'h7);
		apb(1'b1, badr(8'h52), 32'h0);
		apb(1'b1, badr(8'h57), 32'hC9);
		apb(1'b1, badr(8'h4F), {24'h0, pc});
		apb(1'b1, badr(8'h59), 32'h0);
		// Exported settings trail the register by one edge
		@(negedge pclk);
		check("ch4 code", {24'h0, pc}, {24'h0, code4});
		check("ch6_cfg", 32'h0, {19'h0, cfg6.phase, 5'h0});
		stream(pc, 1'b1);
		apb(1'b1, badr(8'h60), 32'h0);
		stream(8'h0, 1'b0);
		tally_and_finish();
	end
endmodule
